// ==== design/plb_selftest.sv ====
// Loopback routing and PRBS self-test logic of a 10/100/1000 transceiver.
// Assumes byte streams on the MAC and line sides, one byte per enabled clock,
// and a synchronous management register port driven by the station manager.
`timescale 1ns/1ps
`default_nettype none

module plb_selftest #(
    parameter int IPG_BYTES  = 12,
    parameter int LOCK_BYTES = 4,
    parameter int LOSS_BYTES = 8
) (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [plb_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [plb_pkg::DATA_W-1:0] reg_wdata,
    output var  logic [plb_pkg::DATA_W-1:0] reg_rdata,
    output var  logic                    reg_rvalid,
    input  wire logic                    speed_gig,
    input  wire plb_pkg::plb_byte_t      mac_tx,
    output var  plb_pkg::plb_byte_t      mac_rx,
    output var  plb_pkg::plb_byte_t      line_tx,
    input  wire plb_pkg::plb_byte_t      line_rx
);
    import plb_pkg::*;

    generate
        if (IPG_BYTES < 1 || IPG_BYTES > 255 || LOCK_BYTES < 1 || LOCK_BYTES > 255 ||
            LOSS_BYTES < 1 || LOSS_BYTES > 255) begin : g_bad_param
            $error("plb_selftest: byte counts must lie in 1..255");
        end
    endgenerate

    // Last index of each byte count; counters start from zero
    localparam logic [7:0] IPG_LAST  = 8'(IPG_BYTES - 1);
    localparam logic [7:0] LOCK_LAST = 8'(LOCK_BYTES - 1);
    localparam logic [7:0] LOSS_LAST = 8'(LOSS_BYTES - 1);

    // State of the block apart from the line output register
    typedef struct packed {
        logic [15:0] basic_control;
        logic [15:0] loop_ctrl;
        logic [15:0] loopback_setup;
        logic [15:0] rdata;
        logic        rvalid;
        plb_byte_t   tx_s0;      // MAC interface stage
        plb_byte_t   tx_s1;      // Coding stage
        plb_byte_t   tx_s2;      // Digital processing stage
        plb_byte_t   tx_s3;      // Analog front end stage
        plb_byte_t   rx_r3;
        plb_byte_t   rx_r2;
        plb_byte_t   rx_r1;
        plb_byte_t   rx_r0;
        plb_byte_t   mac_out;
        logic        test_en_q;
        plb_gen_t    gen_state;
        logic [10:0] gen_cnt;
        logic [7:0]  gap_cnt;
        logic [14:0] gen_lfsr;
        logic [14:0] chk_hist;
        logic [7:0]  match_run;
        logic [7:0]  miss_run;
        logic        locked;
        logic        sync_lost;
        logic [15:0] rx_bytes;
        logic [15:0] err_bytes;
    } plb_state_t;

    plb_state_t st;
    plb_state_t next_st;

    // Advance the 15-bit PRBS by eight bits; new byte is the low eight bits
    function automatic logic [14:0] prbs_step8(input logic [14:0] s);
        logic [14:0] v;
        v = s;
        for (int i = 0; i < 8; i++) begin
            v = {v[13:0], v[14] ^ v[13]};
        end
        return v;
    endfunction

    // Counter step: wrap in continuous mode, else hold at maximum
    // Holding keeps a long run readable instead of silently restarting
    function automatic logic [15:0] cnt_step(input logic [15:0] c, input logic cont);
        logic [15:0] r;
        r = c + 16'h0001;
        if (c == CNT_MAX) begin
            r = cont ? 16'h0000 : CNT_MAX;
        end
        return r;
    endfunction

    // Loop point selection and derived controls
    plb_loop_t   loop_sel;
    logic        test_en;
    logic        test_start;
    logic        cont_mode;
    logic [10:0] pkt_last;
    plb_byte_t   gen_byte;
    plb_byte_t   tx_src;
    plb_byte_t   chk_in;
    logic [14:0] gen_next;
    logic [14:0] chk_next;
    logic [7:0]  chk_pred;
    logic [15:0] status_word;

    // Fixed priority among loop selection bits
    // Shallowest loop wins so a stray deeper bit cannot steal the path
    // External loop is dropped at gigabit speed
    always_comb begin
        loop_sel = LP_NONE;
        if (st.basic_control[BC_MII_LOOP]) begin
            loop_sel = LP_MII;
        end else if (st.loop_ctrl[SC_PCS_LOOP]) begin
            loop_sel = LP_PCS;
        end else if (st.loop_ctrl[SC_DIG_LOOP]) begin
            loop_sel = LP_DIG;
        end else if (st.loop_ctrl[SC_ANA_LOOP]) begin
            loop_sel = LP_ANA;
        end else if (st.loop_ctrl[SC_EXT_LOOP] && !speed_gig) begin
            loop_sel = LP_EXT;
        end else if (st.loop_ctrl[SC_REV_LOOP]) begin
            loop_sel = LP_REV;
        end
    end

    // Self-test controls
    assign test_en    = st.loop_ctrl[SC_TEST_EN];
    assign test_start = test_en && !st.test_en_q;
    assign cont_mode  = st.loop_ctrl[SC_CONTINUOUS];
    assign pkt_last   = (st.loop_ctrl[SC_LONG_PKT] ? PKT_LEN_LONG : PKT_LEN_SHORT) - 11'd1;
    assign gen_next   = prbs_step8(st.gen_lfsr);
    assign chk_next   = prbs_step8(st.chk_hist);
    assign chk_pred   = chk_next[7:0];
    assign status_word = {13'h0000, st.gen_state != GEN_IDLE, st.sync_lost, st.locked};

    // Generator output byte: payload in packets, silence in the gap
    always_comb begin
        gen_byte.valid = (st.gen_state == GEN_PKT);
        gen_byte.data  = gen_next[7:0];
    end

    // Transmit source: reverse loop, self test, or the MAC
    always_comb begin
        if (loop_sel == LP_REV) begin
            tx_src = st.rx_r0;
        end else if (test_en) begin
            tx_src = gen_byte;
        end else begin
            tx_src = mac_tx;
        end
    end

    // Checker looks at what reaches the MAC interface
    // In MII loop the byte comes straight from the MAC stage
    assign chk_in = (loop_sel == LP_MII) ? st.tx_s0 : st.rx_r1;

    // Next state
    always_comb begin
        next_st        = st;
        next_st.rvalid = 1'b0;

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_BASIC_CONTROL:      next_st.basic_control  = reg_wdata;
                OFS_SELFTEST_LOOP_CTRL: next_st.loop_ctrl      = reg_wdata;
                OFS_LOOPBACK_SETUP:     next_st.loopback_setup = reg_wdata;
                default: ;
            endcase
        end

        // Register reads, unmapped offsets read zero
        if (reg_rd) begin
            next_st.rvalid = 1'b1;
            unique case (reg_addr)
                OFS_BASIC_CONTROL:      next_st.rdata = st.basic_control;
                OFS_SELFTEST_LOOP_CTRL: next_st.rdata = st.loop_ctrl;
                OFS_SELFTEST_STATUS:    next_st.rdata = status_word;
                OFS_SELFTEST_RX_BYTES:  next_st.rdata = st.rx_bytes;
                OFS_SELFTEST_ERR_BYTES: next_st.rdata = st.err_bytes;
                OFS_LOOPBACK_SETUP:     next_st.rdata = st.loopback_setup;
                default:                next_st.rdata = 16'h0000;
            endcase
        end

        // Transmit chain
        // One register per stage so every loop point has its own tap
        next_st.tx_s0 = tx_src;
        next_st.tx_s1 = st.tx_s0;
        next_st.tx_s2 = st.tx_s1;
        next_st.tx_s3 = st.tx_s2;

        // Receive chain with turnaround taps
        // Deeper loops turn around earlier in this chain and so see
        // more stages, which makes their latency longer
        next_st.rx_r3 = (loop_sel == LP_ANA) ? st.tx_s3 : line_rx;
        next_st.rx_r2 = (loop_sel == LP_DIG) ? st.tx_s2 : st.rx_r3;
        next_st.rx_r1 = (loop_sel == LP_PCS) ? st.tx_s1 : st.rx_r2;
        next_st.rx_r0 = chk_in;

        // MAC receive output; reverse loop forwards only on request
        next_st.mac_out = st.rx_r0;
        if (loop_sel == LP_REV && !st.loop_ctrl[SC_REV_TO_MAC]) begin
            next_st.mac_out.valid = 1'b0;
        end

        // Packet generator
        // Free-running against the checker; only the packet state
        // and the LFSR move, the gap sends no valid bytes
        next_st.test_en_q = test_en;
        unique case (st.gen_state)
            GEN_IDLE: begin
                if (test_en) begin
                    next_st.gen_state = GEN_PKT;
                    next_st.gen_cnt   = 11'd0;
                end
            end
            GEN_PKT: begin
                next_st.gen_lfsr = gen_next;
                // Length may shrink mid-packet; end at once then
                if (st.gen_cnt >= pkt_last) begin
                    next_st.gen_state = GEN_GAP;
                    next_st.gap_cnt   = 8'h00;
                end else begin
                    next_st.gen_cnt = st.gen_cnt + 11'd1;
                end
            end
            GEN_GAP: begin
                if (st.gap_cnt == IPG_LAST) begin
                    next_st.gen_state = test_en ? GEN_PKT : GEN_IDLE;
                    next_st.gen_cnt   = 11'd0;
                end else begin
                    next_st.gap_cnt = st.gap_cnt + 8'h01;
                end
            end
        endcase

        // Checker: self-synchronising reference from received history
        // The last 15 received bits rebuild the generator state, so no
        // seed exchange is needed; a bad bit upsets a few predictions
        // Errors count only while locked, so start-up bytes are free
        if (test_start) begin
            next_st.chk_hist  = 15'h0000;
            next_st.match_run = 8'h00;
            next_st.miss_run  = 8'h00;
            next_st.locked    = 1'b0;
            next_st.sync_lost = 1'b0;
            next_st.rx_bytes  = 16'h0000;
            next_st.err_bytes = 16'h0000;
        end else if (test_en && st.rx_r0.valid) begin
            next_st.chk_hist = {st.chk_hist[6:0], st.rx_r0.data};
            next_st.rx_bytes = cnt_step(st.rx_bytes, cont_mode);
            if (st.rx_r0.data == chk_pred) begin
                next_st.miss_run = 8'h00;
                if (!st.locked) begin
                    if (st.match_run == LOCK_LAST) begin
                        next_st.locked = 1'b1;
                    end else begin
                        next_st.match_run = st.match_run + 8'h01;
                    end
                end
            end else begin
                next_st.match_run = 8'h00;
                if (st.locked) begin
                    next_st.err_bytes = cnt_step(st.err_bytes, cont_mode);
                    if (st.miss_run == LOSS_LAST) begin
                        next_st.locked    = 1'b0;
                        next_st.sync_lost = 1'b1;
                        next_st.miss_run  = 8'h00;
                    end else begin
                        next_st.miss_run = st.miss_run + 8'h01;
                    end
                end
            end
        end
    end

    // State register, frozen while the clock enable is low
    // Reset loads constants only; the seed must be nonzero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st                <= '0;
            st.basic_control  <= RST_BASIC_CONTROL;
            st.loop_ctrl      <= RST_SELFTEST_LOOP_CTRL;
            st.loopback_setup <= RST_LOOPBACK_SETUP;
            st.gen_state      <= GEN_IDLE;
            st.gen_lfsr       <= PRBS_SEED;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Line output: quiet during internal near-end loops, except MII loop with SC_MII_TO_LINE set
    // Kept apart so the quiet mask sees the current loop choice
    plb_byte_t line_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            line_q <= '0;
        end else if (ce) begin
            line_q <= st.tx_s3;
            if ((loop_sel == LP_MII && !st.loop_ctrl[SC_MII_TO_LINE]) ||
                loop_sel == LP_PCS || loop_sel == LP_DIG || loop_sel == LP_ANA) begin
                line_q.valid <= 1'b0;
            end
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata  = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign mac_rx     = st.mac_out;
    assign line_tx    = line_q;

endmodule

`default_nettype wire

// ==== design/plb_pkg.sv ====
// Constants and carrier types for the loopback and PRBS self-test block.
// Assumes a 16-bit management register port with 8-bit register offsets.
package plb_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [7:0] OFS_BASIC_CONTROL       = 8'h00;
    localparam logic [7:0] OFS_SELFTEST_LOOP_CTRL  = 8'h16;
    localparam logic [7:0] OFS_SELFTEST_STATUS     = 8'h17;
    localparam logic [7:0] OFS_SELFTEST_RX_BYTES   = 8'h71;
    localparam logic [7:0] OFS_SELFTEST_ERR_BYTES  = 8'h72;
    localparam logic [7:0] OFS_LOOPBACK_SETUP      = 8'hfe;

    // Reset values
    localparam logic [15:0] RST_BASIC_CONTROL      = 16'h0000;
    localparam logic [15:0] RST_SELFTEST_LOOP_CTRL = 16'h0000;
    localparam logic [15:0] RST_LOOPBACK_SETUP     = 16'h0000;
    localparam logic [15:0] LOOPBACK_SETUP_VALUE   = 16'he720;

    // Field positions: basic control
    localparam int BC_MII_LOOP    = 14;
    // Field positions: self-test / loop control
    localparam int SC_PCS_LOOP    = 0;
    localparam int SC_DIG_LOOP    = 1;
    localparam int SC_ANA_LOOP    = 2;
    localparam int SC_EXT_LOOP    = 3;
    localparam int SC_REV_LOOP    = 4;
    localparam int SC_REV_TO_MAC  = 5;
    localparam int SC_MII_TO_LINE = 6;
    localparam int SC_LONG_PKT    = 13;
    localparam int SC_CONTINUOUS  = 14;
    localparam int SC_TEST_EN     = 15;
    // Field positions: self-test status
    localparam int ST_LOCKED      = 0;
    localparam int ST_SYNC_LOST   = 1;
    localparam int ST_GEN_BUSY    = 2;

    // Packet framing
    localparam logic [10:0] PKT_LEN_SHORT = 11'd64;
    localparam logic [10:0] PKT_LEN_LONG  = 11'd1518;
    localparam logic [14:0] PRBS_SEED     = 15'h7fff;
    localparam logic [15:0] CNT_MAX       = 16'hffff;

    // One byte of a data stream
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } plb_byte_t;

    // Selected loopback point, one-hot
    typedef enum logic [6:0] {
        LP_NONE = 7'b0000001,
        LP_MII  = 7'b0000010,
        LP_PCS  = 7'b0000100,
        LP_DIG  = 7'b0001000,
        LP_ANA  = 7'b0010000,
        LP_EXT  = 7'b0100000,
        LP_REV  = 7'b1000000
    } plb_loop_t;

    // Packet generator states
    typedef enum logic [2:0] {
        GEN_IDLE = 3'b001,
        GEN_PKT  = 3'b010,
        GEN_GAP  = 3'b100
    } plb_gen_t;

endpackage

// ==== verif/plb_selftest_checker.sv ====
// Assertion checker for the loopback and self-test block.
// Sees only the top module ports; loop mode bits are mirrored from register writes.
`timescale 1ns/1ps
`default_nettype none
module plb_selftest_checker (
    input wire logic                          clk_sys,
    input wire logic                          rst,
    input wire logic                          ce,
    input wire logic                          reg_wr,
    input wire logic                          reg_rd,
    input wire logic [plb_pkg::ADDR_W-1:0]    reg_addr,
    input wire logic [plb_pkg::DATA_W-1:0]    reg_wdata,
    input wire logic [plb_pkg::DATA_W-1:0]    reg_rdata,
    input wire logic                          reg_rvalid,
    input wire logic                          speed_gig,
    input wire plb_pkg::plb_byte_t            mac_tx,
    input wire plb_pkg::plb_byte_t            mac_rx,
    input wire plb_pkg::plb_byte_t            line_tx,
    input wire plb_pkg::plb_byte_t            line_rx
);
    import plb_pkg::*;
    logic [15:0] bc;
    logic [15:0] sc;
    logic        m_mii;
    logic        m_pcs;
    logic        m_dig;
    logic        m_ana;
    logic        m_rev;
    logic        near;
    // Mirror of basic control and loop control
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bc <= 16'h0000;
            sc <= 16'h0000;
        end else if (ce && reg_wr) begin
            if (reg_addr == OFS_BASIC_CONTROL) bc <= reg_wdata;
            if (reg_addr == OFS_SELFTEST_LOOP_CTRL) sc <= reg_wdata;
        end
    end
    // Resolved loop point with the generator off
    assign near  = bc[BC_MII_LOOP] || sc[SC_PCS_LOOP] || sc[SC_DIG_LOOP] || sc[SC_ANA_LOOP];
    assign m_mii = bc[BC_MII_LOOP] && !sc[SC_TEST_EN];
    assign m_pcs = !bc[BC_MII_LOOP] && sc[SC_PCS_LOOP] && !sc[SC_TEST_EN];
    assign m_dig = !bc[BC_MII_LOOP] && sc[1:0] == 2'h2 && !sc[SC_TEST_EN];
    assign m_ana = !bc[BC_MII_LOOP] && sc[2:0] == 3'h4 && !sc[SC_TEST_EN];
    assign m_rev = !near && !(sc[SC_EXT_LOOP] && !speed_gig) && sc[SC_REV_LOOP] && !sc[SC_TEST_EN];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    rd_answer_a: assert property (ce && reg_rd |=> reg_rvalid) else $error("read not answered");
    ctrl_readback_a: assert property (ce && reg_rd && reg_addr == OFS_SELFTEST_LOOP_CTRL |=>
        reg_rdata == $past(sc)) else $error("loop control readback wrong");
    mii_loop_a: assert property (m_mii && mac_tx.valid ##3 m_mii |-> mac_rx == $past(mac_tx, 3))
        else $error("mii loop data wrong");
    pcs_loop_a: assert property (m_pcs && mac_tx.valid ##5 m_pcs |-> mac_rx == $past(mac_tx, 5))
        else $error("pcs loop data wrong");
    dig_loop_a: assert property (m_dig && mac_tx.valid ##7 m_dig |-> mac_rx == $past(mac_tx, 7))
        else $error("digital loop data wrong");
    ana_loop_a: assert property (m_ana && mac_tx.valid ##9 m_ana |-> mac_rx == $past(mac_tx, 9))
        else $error("analog loop data wrong");
    near_quiet_a: assert property ((near && !(bc[BC_MII_LOOP] && sc[SC_MII_TO_LINE]))[*6]
        |-> !line_tx.valid) else $error("line driven in near loop");
    mii_line_a: assert property (m_mii && sc[SC_MII_TO_LINE] && mac_tx.valid ##5 m_mii
        |-> line_tx == $past(mac_tx, 5)) else $error("mii line copy wrong");
    rev_quiet_a: assert property ((m_rev && !sc[SC_REV_TO_MAC])[*6] |-> !mac_rx.valid)
        else $error("mac fed in reverse loop");
    rev_fwd_a: assert property (m_rev && sc[SC_REV_TO_MAC] && line_rx.valid ##5 m_rev
        |-> mac_rx == $past(line_rx, 5)) else $error("reverse copy to mac wrong");
endmodule

bind plb_selftest plb_selftest_checker i_plb_selftest_checker (.clk_sys, .rst, .ce, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .speed_gig, .mac_tx, .mac_rx, .line_tx, .line_rx);
`default_nettype wire

// ==== verif/plb_mac_model.sv ====
// MAC-side traffic model for the loopback and self-test block.
// Sends a counting byte stream while enabled; launches after the falling edge.
`timescale 1ns/1ps
`default_nettype none
module plb_mac_model (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                en,
    output var  plb_pkg::plb_byte_t  mac_tx
);
    import plb_pkg::*;
    logic [7:0] cnt = 8'h00;
    // Data keeps moving when idle so a stale byte never repeats
    always @(negedge clk_sys) begin
        cnt <= cnt + 8'h01;
        mac_tx.valid <= en && !rst;
        mac_tx.data <= cnt;
    end
endmodule
`default_nettype wire

// ==== verif/plb_selftest_tb_top.sv ====
// Testbench for the loopback and self-test block.
// Register port and line side driven at the falling edge; MAC side from the model.
`timescale 1ns/1ps
`default_nettype none
module plb_selftest_tb_top;
    import plb_pkg::*;
    localparam logic [7:0] REGS [7] = '{8'h00, 8'h16, 8'h17, 8'h71, 8'h72, 8'hfe, 8'h33};
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic        reg_rvalid;
    logic        speed_gig = 1'b0;
    logic        mac_en = 1'b0;
    logic        cable = 1'b0;
    logic        spoil = 1'b0;
    plb_byte_t   mac_tx;
    plb_byte_t   mac_rx;
    plb_byte_t   line_tx;
    plb_byte_t   line_rx = '0;
    logic [15:0] rv;
    logic [7:0]  d1;
    int          failures = 0;
    int          n_tests = 0;

    always #5 clk_sys = ~clk_sys;

    plb_selftest #(.IPG_BYTES(12), .LOCK_BYTES(4), .LOSS_BYTES(8)) i_plb_selftest (.clk_sys, .rst, .ce,
        .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .speed_gig, .mac_tx, .mac_rx,
        .line_tx, .line_rx);
    plb_mac_model i_plb_mac_model (.clk_sys, .rst, .en(mac_en), .mac_tx);

    // Cable fixture with one spoilt bit on request, else a far-end stream stepping by 3
    always @(negedge clk_sys) begin
        if (cable) begin
            line_rx <= '{line_tx.valid, line_tx.data ^ {7'h00, spoil && line_tx.valid}};
            if (line_tx.valid) spoil <= 1'b0;
        end else begin
            line_rx <= '{1'b1, line_rx.data + 8'h03};
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk({15'h0000, reg_rvalid}, 16'h0001);
        d = reg_rdata;
    endtask

    // Measures one generated packet and the gap after it on the line
    task automatic frame(input int len);
        int run;
        int gap;
        run = 0;
        gap = 0;
        repeat (2000) if (line_tx.valid === 1'b1) @(negedge clk_sys);
        repeat (2000) if (line_tx.valid !== 1'b1) @(negedge clk_sys);
        while (line_tx.valid === 1'b1 && run < 2000) begin
            run++;
            @(negedge clk_sys);
        end
        while (line_tx.valid !== 1'b1 && gap < 100) begin
            gap++;
            @(negedge clk_sys);
        end
        chk(16'(run), 16'(len));
        chk(16'(gap), 16'd12);
    endtask

    task automatic report_and_stop;
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog sized above the saturation run
    initial begin
        #1_000_000;
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        foreach (REGS[i]) begin
            rd(REGS[i], rv);
            chk(rv, 16'h0000);
        end
        // Write while frozen must not land
        ce = 1'b0;
        wr(8'h00, 16'h4000);
        ce = 1'b1;
        rd(8'h00, rv);
        chk(rv, 16'h0000);
        wr(8'h71, 16'h1234);
        rd(8'h71, rv);
        chk(rv, 16'h0000);
        wr(8'hfe, 16'he720);
        rd(8'hfe, rv);
        chk(rv, 16'he720);
        // Near-end loops with the MAC streaming
        mac_en = 1'b1;
        wr(8'h00, 16'h4000);
        wr(8'h16, 16'h0007);
        repeat (20) @(negedge clk_sys);
        chk({15'h0000, line_tx.valid}, 16'h0000);
        wr(8'h16, 16'h0047);
        repeat (20) @(negedge clk_sys);
        chk({15'h0000, line_tx.valid}, 16'h0001);
        wr(8'h00, 16'h0000);
        speed_gig = 1'b1;
        foreach (REGS[i]) begin
            if (i < 3) begin
                wr(8'h16, 16'h0001 << i);
                repeat (20) @(negedge clk_sys);
                chk({15'h0000, mac_rx.valid}, 16'h0001);
                chk({15'h0000, line_tx.valid}, 16'h0000);
            end
        end
        speed_gig = 1'b0;
        // Reverse loop: line data goes back out, MAC data ignored
        wr(8'h16, 16'h0010);
        repeat (20) @(negedge clk_sys);
        chk({15'h0000, mac_rx.valid}, 16'h0000);
        d1 = line_tx.data;
        @(negedge clk_sys);
        chk({8'h00, 8'(line_tx.data - d1)}, 16'h0003);
        wr(8'h16, 16'h0030);
        repeat (20) @(negedge clk_sys);
        chk({15'h0000, mac_rx.valid}, 16'h0001);
        // Self test through the cable fixture
        mac_en = 1'b0;
        wr(8'h16, 16'h0000);
        cable = 1'b1;
        wr(8'h16, 16'h8008);
        frame(64);
        repeat (200) @(negedge clk_sys);
        rd(8'h17, rv);
        chk(rv, 16'h0005);
        @(posedge clk_sys);
        spoil = 1'b1;
        repeat (200) @(negedge clk_sys);
        rd(8'h72, rv);
        chk({15'h0000, rv inside {[16'h0001:16'h0003]}}, 16'h0001);
        wr(8'h16, 16'ha008);
        frame(1518);
        // Digital loop run until the byte counter saturates
        cable = 1'b0;
        wr(8'h16, 16'h0000);
        wr(8'h16, 16'h8002);
        repeat (78600) @(negedge clk_sys);
        rd(8'h71, rv);
        chk(rv, 16'hffff);
        rd(8'h72, rv);
        chk(rv, 16'h0000);
        wr(8'h16, 16'hc002);
        repeat (40) @(negedge clk_sys);
        rd(8'h71, rv);
        chk({15'h0000, rv < 16'd100}, 16'h0001);
        report_and_stop();
    end
endmodule
`default_nettype wire
